// ---- hdl/psg_params.svh ----
`ifndef PSG_PARAMS_SVH
`define PSG_PARAMS_SVH
// ****************************************
// Time base
// ****************************************
`define PSG_CLK_PERIOD_PS 4000
`define PSG_MS_PS 1000000000
`define PSG_TICK_CYC (`PSG_MS_PS / `PSG_CLK_PERIOD_PS)
`define PSG_HALF_CYC (`PSG_TICK_CYC / 2)
`define PSG_HALF_US 500
// ****************************************
// Register offsets
// ****************************************
`define PSG_OFF_CTRL 8'h00
`define PSG_OFF_RATE 8'h04
`define PSG_OFF_ACTION 8'h08
`define PSG_OFF_STATUS 8'h0c
`define PSG_OFF_ANOM_INT 8'h10
`define PSG_OFF_ANOM_CNT 8'h14
`define PSG_OFF_ADJ_INT 8'h18
`define PSG_OFF_ADJ_CNT 8'h1c
// ****************************************
// Control fields and reset values
// ****************************************
`define PSG_CTRL_MODE_LSB 0
`define PSG_CTRL_VT_BIT 2
`define PSG_CTRL_TYPE_LSB 3
`define PSG_CTRL_DIR_BIT 7
`define PSG_CTRL_RATE_LSB 8
`define PSG_CTRL_INIT_BIT 11
`define PSG_CTRL_COOL_BIT 12
`define PSG_CTRL_RST 13'h0000
`define PSG_RATE_RST 14'h03e8
// ****************************************
// Sequence timing, in ms unless noted; the G, L and A values are slot counts
// ****************************************
`define PSG_INIT_MS 30000
`define PSG_INIT_STEP_MS 1000
`define PSG_COOL_MIN_MS 60000
`define PSG_ANOM_MIN_MS 30000
`define PSG_ALT_MS 30000
`define PSG_RATE0_MS 1000
`define PSG_RATE1_MS 2000
`define PSG_RATE2_MS 5000
`define PSG_RATE3_MS 10000
`define PSG_RATE_MAX_MS 10000
`define PSG_VT_MIN_MS 1000
`define PSG_STS_MIN_MS 340
`define PSG_CONT_MIN_MS 34
`define PSG_VT_ADD_US 2000
`define PSG_STS_ADD_US 500
`define PSG_G26 26
`define PSG_L26 27
`define PSG_A26 13
`define PSG_G87 87
`define PSG_L87 90
`define PSG_A87 43
`endif

// ---- hdl/psg_pkg.sv ----
package psg_pkg;
   typedef enum logic [1:0] {
      RUN_IDLE = 2'b00,
      RUN_INIT = 2'b01,
      RUN_COOL = 2'b10,
      RUN_SEQ = 2'b11
   } psg_run_t;
   typedef enum logic [3:0] {
      SQ_SINGLE = 4'h0, SQ_BURST = 4'h1, SQ_PHASE = 4'h2, SQ_CONT = 4'h3,
      SQ_CONT_C = 4'h4, SQ_CONT_A = 4'h5, SQ_P87 = 4'h6, SQ_P87_C = 4'h7,
      SQ_P87_A = 4'h8, SQ_P26 = 4'h9, SQ_P26_C = 4'ha, SQ_P26_A = 4'hb,
      SQ_SALT = 4'hc, SQ_DALT = 4'hd
   } psg_seq_t;
   typedef enum logic [1:0] {
      MODE_FIXED = 2'b00,
      MODE_FREQ = 2'b01,
      MODE_SEQ = 2'b10
   } psg_mode_t;
   typedef struct packed {
      psg_run_t run;
      logic pend;
      logic refused;
      logic calc_done;
      logic [12:0] ctrl;
      logic [13:0] urate;
      logic [19:0] half_cnt;
      logic half_ph;
      logic [23:0] anom_int;
      logic [11:0] nmax;
      logic [11:0] ncyc;
      logic [23:0] anom_cnt;
      logic [23:0] adj_cnt;
      logic [6:0] slot;
      logic [23:0] ph_cnt;
      logic [2:0] extra;
      logic alt_dec;
      logic move;
      logic move_dec;
      logic [31:0] rdata;
   } psg_state_t;
endpackage

// ---- hdl/psg_gen.sv ----
`timescale 1ns/1ps
`include "psg_params.svh"
`default_nettype none
module psg_gen #(
   parameter int TICK_CYC = `PSG_TICK_CYC,
   parameter int HALF_CYC = `PSG_HALF_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Pointer movement and status
   output logic ptr_move,
   output logic ptr_dec,
   output logic [1:0] run_state
);
   // ****************************************
   // Decode helpers
   // ****************************************
   function automatic logic [13:0] rate_ms(input logic [2:0] sel,
                                           input logic [13:0] usr);
      case (sel)
         3'h0: rate_ms = 14'(`PSG_RATE0_MS);
         3'h1: rate_ms = 14'(`PSG_RATE1_MS);
         3'h2: rate_ms = 14'(`PSG_RATE2_MS);
         3'h3: rate_ms = 14'(`PSG_RATE3_MS);
         default: rate_ms = usr;
      endcase
   endfunction

   function automatic logic fam26(input psg_pkg::psg_seq_t t);
      fam26 = (t == psg_pkg::SQ_P26) || (t == psg_pkg::SQ_P26_C) ||
              (t == psg_pkg::SQ_P26_A);
   endfunction

   function automatic logic fam87(input psg_pkg::psg_seq_t t);
      fam87 = (t == psg_pkg::SQ_P87) || (t == psg_pkg::SQ_P87_C) ||
              (t == psg_pkg::SQ_P87_A);
   endfunction

   // Burst, phase transient and continuous cancel/add are not built and are always refused
   function automatic logic type_ok(input psg_pkg::psg_seq_t t,
                                    input logic vt);
      if (fam26(t)) begin
         type_ok = vt;
      end else if (fam87(t)) begin
         type_ok = !vt;
      end else begin
         type_ok = (t == psg_pkg::SQ_SINGLE) || (t == psg_pkg::SQ_CONT) ||
                   (t == psg_pkg::SQ_SALT) || (t == psg_pkg::SQ_DALT);
      end
   endfunction

   psg_pkg::psg_state_t q, d;
   psg_pkg::psg_seq_t styp;
   logic vt, cdir, is26, is87, cancel, add, anom, alt, fix30, valid, rng_ok;
   logic half, tick, act_wr;
   logic [1:0] mode;
   logic [13:0] ival;
   logic [6:0] grp, len, apos;
   logic [23:0] adj_int, per, first, cool_ms;
   logic [2:0] addh;

   assign mode = q.ctrl[`PSG_CTRL_MODE_LSB +: 2];
   assign vt = q.ctrl[`PSG_CTRL_VT_BIT];
   assign styp = psg_pkg::psg_seq_t'(q.ctrl[`PSG_CTRL_TYPE_LSB +: 4]);
   assign cdir = q.ctrl[`PSG_CTRL_DIR_BIT];
   assign ival = rate_ms(q.ctrl[`PSG_CTRL_RATE_LSB +: 3], q.urate);
   assign is26 = fam26(styp);
   assign is87 = fam87(styp);
   assign cancel = (styp == psg_pkg::SQ_P26_C) || (styp == psg_pkg::SQ_P87_C);
   assign add = (styp == psg_pkg::SQ_P26_A) || (styp == psg_pkg::SQ_P87_A);
   assign anom = cancel || add;
   assign alt = (styp == psg_pkg::SQ_SALT) || (styp == psg_pkg::SQ_DALT);
   assign fix30 = alt || (styp == psg_pkg::SQ_SINGLE);
   assign grp = is87 ? 7'(`PSG_G87) : 7'(`PSG_G26);
   assign len = is87 ? 7'(`PSG_L87) : 7'(`PSG_L26);
   assign apos = cancel ? grp : (is87 ? 7'(`PSG_A87) : 7'(`PSG_A26));
   assign adj_int = fix30 ? 24'(`PSG_ALT_MS) : {10'h000, ival};
   assign per = 24'(ival * len);
   assign first = 24'(ival * apos);
   // Added move delay counted in half-ms steps
   assign addh = vt ? 3'(`PSG_VT_ADD_US / `PSG_HALF_US)
                    : 3'(`PSG_STS_ADD_US / `PSG_HALF_US);
   assign cool_ms = (anom && q.anom_int > 24'(`PSG_COOL_MIN_MS)) ?
                    q.anom_int : 24'(`PSG_COOL_MIN_MS);
   always_comb begin
      if (is26) begin
         rng_ok = ival >= 14'(`PSG_VT_MIN_MS);
      end else if (is87) begin
         rng_ok = ival >= 14'(`PSG_STS_MIN_MS);
      end else if (styp == psg_pkg::SQ_CONT) begin
         rng_ok = ival >= 14'(`PSG_CONT_MIN_MS);
      end else begin
         rng_ok = 1'b1;
      end
      if (!fix30 && ival > 14'(`PSG_RATE_MAX_MS)) begin
         rng_ok = 1'b0;
      end
   end
   assign valid = (mode == psg_pkg::MODE_SEQ) && type_ok(styp, vt) &&
                  rng_ok;
   assign act_wr = reg_wr && (reg_addr == `PSG_OFF_ACTION);
   assign half = q.half_cnt == 20'(HALF_CYC - 1);
   assign tick = half && q.half_ph;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic go_seq;
      logic fire;
      logic fdir;
      go_seq = 1'b0;
      fire = 1'b0;
      fdir = alt ? q.alt_dec : cdir;
      d = q;
      d.move = 1'b0;
      d.half_cnt = half ? 20'h00000 : q.half_cnt + 20'h00001;
      d.half_ph = half ? !q.half_ph : q.half_ph;
      // N search: adds one pattern period (len intervals) until 30 s is reached
      if (!q.calc_done) begin
         if (q.anom_int < 24'(`PSG_ANOM_MIN_MS) && per != 24'h000000) begin
            d.anom_int = q.anom_int + per;
            d.nmax = q.nmax + 12'h001;
         end else begin
            d.calc_done = 1'b1;
         end
      end
      if (q.run == psg_pkg::RUN_INIT && tick) begin
         d.ph_cnt = q.ph_cnt - 24'h000001;
         d.adj_cnt = q.adj_cnt - 24'h000001;
         if (q.adj_cnt == 24'h000001) begin
            d.adj_cnt = 24'(`PSG_INIT_STEP_MS);
            fire = 1'b1;
            fdir = cdir;
         end
         if (q.ph_cnt == 24'h000001) begin
            go_seq = 1'b1;
         end
      end
      if (q.run[1] && half && q.extra != 3'h0) begin
         d.extra = q.extra - 3'h1;
         if (q.extra == 3'h1) begin
            fire = 1'b1;
            if (styp == psg_pkg::SQ_DALT) begin
               d.alt_dec = !q.alt_dec;
            end
         end
      end
      // Cool-down and running both drive the pattern
      if (q.run[1] && tick) begin
         if (q.run == psg_pkg::RUN_COOL) begin
            d.ph_cnt = q.ph_cnt - 24'h000001;
            if (q.ph_cnt == 24'h000001) begin
               d.run = psg_pkg::RUN_SEQ;
            end
         end
         if (anom) begin
            d.anom_cnt = q.anom_cnt - 24'h000001;
         end
         d.adj_cnt = q.adj_cnt - 24'h000001;
         if (q.adj_cnt == 24'h000001) begin
            d.adj_cnt = adj_int;
            if (is26 || is87) begin
               fire = q.slot < grp;
               if (anom && q.ncyc == 12'h000 && q.slot == apos - 7'h01) begin
                  d.anom_cnt = q.anom_int;
                  if (cancel) begin
                     fire = 1'b0;
                  end else begin
                     d.extra = addh;
                  end
               end
               d.slot = q.slot + 7'h01;
               if (q.slot == len - 7'h01) begin
                  d.slot = 7'h00;
                  d.ncyc = (q.ncyc == q.nmax - 12'h001) ? 12'h000
                           : q.ncyc + 12'h001;
               end
            end else begin
               fire = 1'b1;
               if (styp == psg_pkg::SQ_SALT) begin
                  d.alt_dec = !q.alt_dec;
               end else if (styp == psg_pkg::SQ_DALT) begin
                  // Pairs are 2 ms apart whatever the pointer type
                  d.extra = 3'(`PSG_VT_ADD_US / `PSG_HALF_US);
               end
            end
         end
      end
      if (go_seq || (q.pend && q.calc_done && !q.ctrl[`PSG_CTRL_INIT_BIT])) begin
         d.run = q.ctrl[`PSG_CTRL_COOL_BIT] ? psg_pkg::RUN_COOL
                                             : psg_pkg::RUN_SEQ;
         d.ph_cnt = cool_ms;
         d.adj_cnt = adj_int;
         d.slot = 7'h00;
         d.ncyc = 12'h000;
         d.anom_cnt = anom ? first : 24'h000000;
         d.alt_dec = 1'b0;
         d.extra = 3'h0;
         d.pend = 1'b0;
      end else if (q.pend && q.calc_done) begin
         d.run = psg_pkg::RUN_INIT;
         d.ph_cnt = 24'(`PSG_INIT_MS);
         d.adj_cnt = 24'(`PSG_INIT_STEP_MS);
         d.pend = 1'b0;
      end
      d.move = fire;
      d.move_dec = fire ? fdir : q.move_dec;
      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            `PSG_OFF_CTRL: begin
               d.ctrl = reg_wdata[12:0];
               d.calc_done = 1'b0;
               d.anom_int = 24'h000000;
               d.nmax = 12'h000;
            end
            `PSG_OFF_RATE: begin
               d.urate = reg_wdata[13:0];
               d.calc_done = 1'b0;
               d.anom_int = 24'h000000;
               d.nmax = 12'h000;
            end
            default: begin
            end
         endcase
      end
      if (act_wr) begin
         if (q.run != psg_pkg::RUN_IDLE || q.pend) begin
            d.run = psg_pkg::RUN_IDLE;
            d.pend = 1'b0;
            d.move = 1'b0;
            d.extra = 3'h0;
         end else if (valid) begin
            d.pend = 1'b1;
            d.refused = 1'b0;
         end else begin
            d.refused = 1'b1;
         end
      end
      if (mode != psg_pkg::MODE_SEQ && q.run != psg_pkg::RUN_IDLE) begin
         d.run = psg_pkg::RUN_IDLE;
         d.pend = 1'b0;
         d.move = 1'b0;
         d.extra = 3'h0;
      end
      // Read data stands one cycle only
      d.rdata = 32'h00000000;
      if (reg_rd) begin
         case (reg_addr)
            `PSG_OFF_CTRL: d.rdata = {19'h00000, q.ctrl};
            `PSG_OFF_RATE: d.rdata = {18'h00000, q.urate};
            `PSG_OFF_STATUS: d.rdata = {28'h0000000, q.pend, q.refused,
                                        q.run};
            `PSG_OFF_ANOM_INT: d.rdata = {8'h00, anom ? q.anom_int
                                                      : 24'h000000};
            `PSG_OFF_ANOM_CNT: d.rdata = {8'h00, q.anom_cnt};
            `PSG_OFF_ADJ_INT: d.rdata = {8'h00, adj_int};
            `PSG_OFF_ADJ_CNT: d.rdata = {8'h00, q.adj_cnt};
            default: d.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.run <= psg_pkg::RUN_IDLE;
         q.ctrl <= `PSG_CTRL_RST;
         q.urate <= `PSG_RATE_RST;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign ptr_move = q.move;
   assign ptr_dec = q.move_dec;
   assign run_state = q.run;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_idle_no_move: assert property (
      q.run == psg_pkg::RUN_IDLE && !q.pend |=> !ptr_move)
      else $error("movement while idle");
   a_vt_87_refused: assert property (
      act_wr && q.run == psg_pkg::RUN_IDLE && !q.pend && vt && is87
      |=> q.refused && !q.pend && q.run == psg_pkg::RUN_IDLE)
      else $error("87-3 accepted with VT pointer");
   a_sts_26_refused: assert property (
      act_wr && q.run == psg_pkg::RUN_IDLE && !q.pend && !vt && is26
      |=> q.refused && !q.pend)
      else $error("26-1 accepted with STS pointer");
   a_mode_gate_stop: assert property (
      mode != psg_pkg::MODE_SEQ && q.run != psg_pkg::RUN_IDLE
      |=> q.run == psg_pkg::RUN_IDLE)
      else $error("sequence kept running outside sequence mode");
   a_action_stops: assert property (
      act_wr && q.run != psg_pkg::RUN_IDLE |=> q.run == psg_pkg::RUN_IDLE)
      else $error("second action did not stop");
   a_cancel_span: assert property (
      q.calc_done && cancel && q.run != psg_pkg::RUN_IDLE
      |-> q.anom_int >= 24'(`PSG_ANOM_MIN_MS) &&
          q.anom_int - per < 24'(`PSG_ANOM_MIN_MS))
      else $error("cancel spacing not smallest multiple");
   a_add_span: assert property (
      q.calc_done && add && q.run != psg_pkg::RUN_IDLE
      |-> q.anom_int == 24'(per * q.nmax) &&
          q.anom_int >= 24'(`PSG_ANOM_MIN_MS))
      else $error("add spacing wrong");
   a_extra_fires: assert property (
      q.run[1] && half && q.extra == 3'h1 && !act_wr &&
      mode == psg_pkg::MODE_SEQ |=> ptr_move)
      else $error("added movement missing");
   a_init_dir: assert property (
      q.run == psg_pkg::RUN_INIT && ptr_move |-> ptr_dec == cdir)
      else $error("init movement in wrong direction");
   a_init_len: assert property (
      $changed(q.run) && q.run == psg_pkg::RUN_INIT
      |-> q.ph_cnt == 24'(`PSG_INIT_MS))
      else $error("init length not 30 s");
   a_cool_len: assert property (
      $changed(q.run) && q.run == psg_pkg::RUN_COOL
      |-> q.ph_cnt >= 24'(`PSG_COOL_MIN_MS))
      else $error("cool down shorter than 60 s");
   a_cool_skip: assert property (
      q.run == psg_pkg::RUN_SEQ && $past(q.run) != psg_pkg::RUN_SEQ &&
      $past(q.run) != psg_pkg::RUN_COOL
      |-> !$past(q.ctrl[`PSG_CTRL_COOL_BIT]))
      else $error("cool down skipped while enabled");
   a_init_enable: assert property (
      q.run == psg_pkg::RUN_INIT && $past(q.run) != psg_pkg::RUN_INIT
      |-> $past(q.ctrl[`PSG_CTRL_INIT_BIT]))
      else $error("initialization entered while disabled");
   a_dalt_flip: assert property (
      ptr_move && styp == psg_pkg::SQ_DALT && q.run[1] && q.extra == 3'h0
      |-> ptr_dec != q.alt_dec)
      else $error("double alternating pair did not flip");
endmodule
`default_nettype wire

// ---- sim/psg_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Receiving network element
// ****************************************
module psg_far_end (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Pointer movements seen on the line
   input wire logic ptr_move,
   input wire logic ptr_dec
);
   // Receive only: a real receiver never throttles the sender
   int cyc;
   int mv_time[$];
   logic mv_dir[$];

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc <= 0;
      end else begin
         cyc <= cyc + 1;
         if (ptr_move === 1'b1) begin
            mv_time.push_back(cyc);
            mv_dir.push_back(ptr_dec);
         end
      end
   end
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`include "psg_params.svh"
`default_nettype none
module testbench;
   // Short millisecond so 30 s patterns fit the run
   localparam int TICK = 2;
   logic core_clk;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic ptr_move;
   logic ptr_dec;
   logic [1:0] run_state;
   int err_total;
   int compares;
   logic [31:0] rv;
   int i;
   int iv;
   int t0;
   int rate_tbl[4] = '{1000, 2000, 5000, 10000};
   logic [31:0] ref_tbl[5];

   psg_gen #(.TICK_CYC(TICK), .HALF_CYC(TICK / 2)) i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ptr_move(ptr_move), .ptr_dec(ptr_dec),
      .run_state(run_state));

   psg_far_end i_far (
      .core_clk(core_clk), .rst_n(rst_n), .ptr_move(ptr_move),
      .ptr_dec(ptr_dec));

   always #2 core_clk = ~core_clk;

   // ****************************************
   // Bench tasks and reference model
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %0d seen %0d", what, exp, seen);
      end
   endtask

   task automatic final_report;
      $display("Counts: %0d compares, %0d errors", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   function automatic logic [31:0] cfg(int mode, int vt, int ty, int dir,
                                       int rsel, int ini, int cool);
      return 32'(mode | vt << 2 | ty << 3 | dir << 7 | rsel << 8 |
                 ini << 11 | cool << 12);
   endfunction

   // Spacing of anomalies: smallest multiple reaching 30 s
   function automatic int anom_ms(int ivl);
      int k;
      k = 1;
      while (ivl * 27 * k < 30000) k++;
      return ivl * 27 * k;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic wait_cond(input int lim, input bit moves, input int cnt,
                            input logic [1:0] st);
      int k;
      k = 0;
      while (k < lim && (moves ? i_far.mv_time.size() < cnt
                               : run_state !== st)) begin
         @(posedge core_clk);
         k++;
      end
      if (k >= lim) begin
         err_total++;
         $display("Error wait expected %0d seen timeout", cnt);
         final_report();
      end
   endtask

   task automatic start_run(input logic [31:0] c);
      i_far.mv_time.delete();
      i_far.mv_dir.delete();
      wr(`PSG_OFF_CTRL, c);
      wr(`PSG_OFF_ACTION, 32'h0000_0001);
      t0 = i_far.cyc;
   endtask

   task automatic stop_run;
      wr(`PSG_OFF_ACTION, 32'h0000_0001);
      repeat (4) @(posedge core_clk);
   endtask

   task automatic check_gaps(input int from, input int to, input int gap,
                             input logic dir);
      int k;
      for (k = from; k <= to; k++) begin
         check("move gap", i_far.mv_time[k] - i_far.mv_time[k - 1], gap);
         check("move dir", 32'(i_far.mv_dir[k]), 32'(dir));
      end
   endtask

   // ****************************************
   // Hang guard
   // ****************************************
   initial begin
      repeat (99000) @(posedge core_clk);
      err_total++;
      $display("Error watchdog expected finish seen timeout");
      final_report();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      core_clk = 1'b0;
      err_total = 0;
      compares = 0;
      rst_n <= 1'b0;
      reg_addr <= 8'h00;
      reg_wdata <= 32'h0000_0000;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      void'($urandom(47));
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(`PSG_OFF_CTRL, rv);
      check("ctrl reset", rv, 32'h0000_0000);
      rd(`PSG_OFF_RATE, rv);
      check("rate reset", rv, 32'h0000_03e8);
      rd(`PSG_OFF_STATUS, rv);
      check("status reset", rv, 32'h0000_0000);
      rd(8'h20, rv);
      check("unmapped read", rv, 32'h0000_0000);
      $display("Test reset done");
      // Presets, a random user rate and the 29997 ms boundary
      for (i = 0; i < 6; i++) begin
         iv = (i < 4) ? rate_tbl[i] : 1000 + int'($urandom % 9001);
         if (i == 5) iv = 1111;
         wr(`PSG_OFF_RATE, 32'(iv));
         wr(`PSG_OFF_CTRL, cfg(2, 1, 10, 0, (i < 4) ? i : 4, 0, 0));
         repeat (8) @(posedge core_clk);
         rd(`PSG_OFF_ANOM_INT, rv);
         check("cancel spacing", rv, 32'(anom_ms(iv)));
         rd(`PSG_OFF_ADJ_INT, rv);
         check("adjust interval", rv, 32'(iv));
         wr(`PSG_OFF_ACTION, 32'h0000_0001);
         repeat (2) @(posedge core_clk);
         check("run state", 32'(run_state), 32'h3);
         if (i == 5) begin
            wr(`PSG_OFF_CTRL, 32'h0000_0000);
            repeat (2) @(posedge core_clk);
            check("mode stop", 32'(run_state), 32'h0);
         end else begin
            stop_run();
         end
      end
      $display("Test rates done");
      ref_tbl = '{cfg(0, 1, 9, 0, 0, 0, 0), cfg(1, 1, 9, 0, 0, 0, 0),
                  cfg(2, 1, 6, 0, 0, 0, 0), cfg(2, 0, 9, 0, 0, 0, 0),
                  cfg(2, 1, 9, 0, 4, 0, 0)};
      for (i = 0; i < 5; i++) begin
         if (i == 4) wr(`PSG_OFF_RATE, 32'd999);
         wr(`PSG_OFF_CTRL, ref_tbl[i]);
         wr(`PSG_OFF_ACTION, 32'h0000_0001);
         repeat (8) @(posedge core_clk);
         rd(`PSG_OFF_STATUS, rv);
         check("refused start", {29'h0, rv[2:0]}, 32'h4);
         check("idle state", 32'(run_state), 32'h0);
      end
      $display("Test refusals done");
      // Initialization burst, decrement, then stop mid-phase
      start_run(cfg(2, 1, 11, 1, 0, 1, 0));
      wait_cond(2000, 1'b0, 0, 2'b01);
      check("init state", 32'(run_state), 32'h1);
      wait_cond(9000, 1'b1, 3, 2'b00);
      check_gaps(1, 2, 1000 * TICK, 1'b1);
      check("first dir", 32'(i_far.mv_dir[0]), 32'h1);
      stop_run();
      check("stopped", 32'(run_state), 32'h0);
      i_far.mv_time.delete();
      repeat (2500) @(posedge core_clk);
      check("no moves stopped", i_far.mv_time.size(), 0);
      $display("Test init done");
      // 26-1 with add, cool down on
      start_run(cfg(2, 1, 11, 0, 0, 0, 1));
      wait_cond(2000, 1'b0, 0, 2'b10);
      check("cool state", 32'(run_state), 32'h2);
      rd(`PSG_OFF_ANOM_INT, rv);
      check("add spacing", rv, 32'(anom_ms(1000)));
      rd(`PSG_OFF_ANOM_CNT, rv);
      check("anom countdown", 32'(rv <= 13000 && rv >= 12900), 32'h1);
      rd(`PSG_OFF_ADJ_CNT, rv);
      check("adj countdown", 32'(rv <= 1000 && rv > 0), 32'h1);
      wait_cond(30000, 1'b1, 14, 2'b00);
      check_gaps(1, 12, 1000 * TICK, 1'b0);
      check_gaps(13, 13, 2 * TICK, 1'b0);
      check("cool still", 32'(run_state), 32'h2);
      stop_run();
      $display("Test add done");
      // Double alternating ignores the decrement setting
      start_run(cfg(2, 0, 13, 1, 0, 0, 0));
      wait_cond(2000, 1'b0, 0, 2'b11);
      check("seq state", 32'(run_state), 32'h3);
      wait_cond(64000, 1'b1, 2, 2'b00);
      iv = i_far.mv_time[0] - t0;
      check("pair spacing", 32'(iv >= 60000 && iv <= 61400), 32'h1);
      check("first dir", 32'(i_far.mv_dir[0]), 32'h0);
      check_gaps(1, 1, 2 * TICK, 1'b0);
      stop_run();
      $display("Test alternating done");
      final_report();
   end
endmodule
`default_nettype wire
